// *** hw/dpt_params.svh ***
// register offsets, field positions, reset values and prescale figures for the dual pwm timer
`ifndef DPT_PARAMS_SVH
`define DPT_PARAMS_SVH
`define DPT_ADDR_W        16
`define DPT_CH0_CTRL_OFS  16'hFFA0
`define DPT_CH0_DUTY_OFS  16'hFFA1
`define DPT_CH0_CNT_OFS   16'hFFA2
`define DPT_CH1_CTRL_OFS  16'hFFA4
`define DPT_CH1_DUTY_OFS  16'hFFA5
`define DPT_CH1_CNT_OFS   16'hFFA6
`define DPT_CH_STRIDE     16'h0004
`define DPT_OE_BIT        7
`define DPT_POL_BIT       6
`define DPT_PSC_HI        2
`define DPT_PSC_LO        0
`define DPT_CTRL_RST      8'h38
`define DPT_CTRL_FIXED    8'h38
`define DPT_CTRL_WMASK    8'hC7
`define DPT_DUTY_RST      8'hFF
`define DPT_CNT_RST       8'h00
`define DPT_CNT_TOP       8'hF9
`define DPT_PSC_W         12
`endif

// *** hw/dpt_pkg.sv ***
// shared types of the dual pwm timer
package dpt_pkg;
  typedef logic [7:0] dpt_byte_t;
  typedef logic [2:0] dpt_psc_t;
endpackage

// *** hw/dpt_prescaler.sv ***
// free-running prescaler giving one-cycle count enables for all eight divide ratios
`timescale 1ns/100ps
`include "dpt_params.svh"
module dpt_prescaler #(
  parameter int PSC_W = `DPT_PSC_W
) (
  input  wire logic       clk,   // module clock
  input  wire logic       rst,   // async reset, active high
  output logic      [7:0] tick   // one pulse per divided period, index = select code
);
  logic [PSC_W-1:0] div_r;
  // bit positions of the ratios 2,8,32,128,256,1024,2048,4096
  localparam int POS [8] = '{0, 2, 4, 6, 7, 9, 10, 11};

  // shared divider: one counter serves both channels, so their periods stay phase locked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) div_r <= '0;
    else     div_r <= div_r + 1'b1;
  end

  // a ratio ticks when all low bits of its window are ones
  for (genvar i = 0; i < 8; i++) begin : g_tick
    assign tick[i] = &div_r[POS[i]:0];
  end
endmodule

// *** hw/dpt_top.sv ***
// dual pwm timer: two identical 8-bit pwm channels behind a plain register port
// Overview of operation
// RULE1: enabled counter steps per selected count clock from 00 to F9, then wraps to 00.
// RULE2: output enable low disables the output and holds the counter cleared at zero.
// RULE3: output enable high drives the pin and lets the counter run continuously.
// RULE4: polarity bit 0 gives positive pulses, bit 1 gives inverted pulses.
// RULE5: select codes 0..7 divide the clock by 2,8,32,128,256,1024,2048,4096.
// RULE6: each channel has a readable writable duty register resetting to all ones.
// RULE7: second channel is an exact copy of the first at its own addresses.
// RULE8: active level while counter below duty, inactive for the rest of the period.
`timescale 1ns/100ps
`include "dpt_params.svh"
module dpt_top #(
  parameter int NCH = 2
) (
  input  wire logic                   clk,      // module clock, 25 MHz
  input  wire logic                   rst,      // async reset, active high
  input  wire logic [`DPT_ADDR_W-1:0] addr,     // register byte address
  input  wire logic [7:0]             wdata,    // write data
  input  wire logic                   wr,       // write strobe, one cycle
  input  wire logic                   rd,       // read strobe, one cycle
  output logic      [7:0]             rdata,    // read data, cycle after rd
  output logic      [NCH-1:0]         pwm_out,  // pwm pins
  output logic      [NCH-1:0]         pwm_oe    // pin drive enables
);
  logic [7:0] tick;
  dpt_pkg::dpt_byte_t ctrl_r [NCH];
  dpt_pkg::dpt_byte_t duty_r [NCH];
  dpt_pkg::dpt_byte_t cnt_r  [NCH];
  dpt_pkg::dpt_byte_t rd_mux;
  logic [NCH-1:0] sel_ctrl;
  logic [NCH-1:0] sel_duty;
  logic [NCH-1:0] sel_cnt;

  dpt_prescaler #(.PSC_W(`DPT_PSC_W)) i_dpt_prescaler (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  // per-channel logic, identical for every channel
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire [`DPT_ADDR_W-1:0] base = `DPT_CH0_CTRL_OFS + `DPT_ADDR_W'(c * `DPT_CH_STRIDE); // RULE7
    wire                   en   = ctrl_r[c][`DPT_OE_BIT];
    wire                   pol  = ctrl_r[c][`DPT_POL_BIT];
    wire dpt_pkg::dpt_psc_t psc = ctrl_r[c][`DPT_PSC_HI:`DPT_PSC_LO];
    wire                   step = tick[psc]; // RULE5
    wire                   act  = cnt_r[c] < duty_r[c]; // RULE8
    wire dpt_pkg::dpt_byte_t cnt_nxt;
    assign sel_ctrl[c] = (addr == base);
    assign sel_duty[c] = (addr == base + 16'h0001);
    assign sel_cnt[c]  = (addr == base + 16'h0002);
    // wrap at the top count; a software write beats the count step
    assign cnt_nxt = !en ? `DPT_CNT_RST :                                     // RULE2
                     (wr && sel_cnt[c]) ? wdata :
                     !step ? cnt_r[c] :
                     (cnt_r[c] == `DPT_CNT_TOP) ? `DPT_CNT_RST : cnt_r[c] + 8'h01; // RULE1 RULE3

    // control: unused bits stay fixed at their read-as-one value
    always_ff @(posedge clk or posedge rst) begin
      if (rst) ctrl_r[c] <= `DPT_CTRL_RST;
      else if (wr && sel_ctrl[c]) ctrl_r[c] <= (wdata & `DPT_CTRL_WMASK) | `DPT_CTRL_FIXED;
    end

    // duty register
    always_ff @(posedge clk or posedge rst) begin
      if (rst) duty_r[c] <= `DPT_DUTY_RST; // RULE6
      else if (wr && sel_duty[c]) duty_r[c] <= wdata; // RULE6
    end

    // counter
    always_ff @(posedge clk or posedge rst) begin
      if (rst) cnt_r[c] <= `DPT_CNT_RST;
      else     cnt_r[c] <= cnt_nxt;
    end

    // pin: registered so the output never glitches on the compare
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pwm_out[c] <= 1'b0;
        pwm_oe[c]  <= 1'b0;
      end else begin
        pwm_out[c] <= en & (act ^ pol); // RULE4 RULE8
        pwm_oe[c]  <= en;               // RULE2 RULE3
      end
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      if (sel_ctrl[i]) rd_mux = ctrl_r[i];
      if (sel_duty[i]) rd_mux = duty_r[i];
      if (sel_cnt[i])  rd_mux = cnt_r[i];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst)     rdata <= 8'h00;
    else if (rd) rdata <= rd_mux;
    else         rdata <= 8'h00;
  end

  // checks
  property p_clear_when_off;
    @(posedge clk) disable iff (rst) !ctrl_r[0][`DPT_OE_BIT] |=> cnt_r[0] == 8'h00;
  endproperty
  a_clear_when_off: assert property (p_clear_when_off) else $error("counter not cleared when disabled"); // RULE2
  property p_wrap;
    @(posedge clk) disable iff (rst) ctrl_r[0][7] && cnt_r[0] == 8'hF9 && g_ch[0].step && !wr |=> cnt_r[0] == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap at F9"); // RULE1
  property p_never_above_top;
    @(posedge clk) disable iff (rst) !(wr && sel_cnt[0]) |=> cnt_r[0] <= 8'hF9 || $past(cnt_r[0]) > 8'hF9;
  endproperty
  a_never_above_top: assert property (p_never_above_top) else $error("counter passed F9"); // RULE1
  property p_hold_no_step;
    @(posedge clk) disable iff (rst) ctrl_r[1][7] && !g_ch[1].step && !wr |=> $stable(cnt_r[1]);
  endproperty
  a_hold_no_step: assert property (p_hold_no_step) else $error("counter moved without tick"); // RULE5
  property p_div2;
    @(posedge clk) disable iff (rst) tick[0] |=> !tick[0] ##1 tick[0];
  endproperty
  a_div2: assert property (p_div2) else $error("divide by 2 tick wrong"); // RULE5
  property p_oe;
    @(posedge clk) disable iff (rst) 1'b1 |=> pwm_oe[0] == $past(ctrl_r[0][7]);
  endproperty
  a_oe: assert property (p_oe) else $error("drive enable not following enable bit"); // RULE3
  property p_level;
    @(posedge clk) disable iff (rst) ctrl_r[1][7] |=> pwm_out[1] == (($past(cnt_r[1]) < $past(duty_r[1])) ^ $past(ctrl_r[1][6])); // RULE4
  endproperty
  a_level: assert property (p_level) else $error("pwm level wrong"); // RULE8
  property p_duty_wr;
    @(posedge clk) disable iff (rst) wr && sel_duty[1] |=> duty_r[1] == $past(wdata);
  endproperty
  a_duty_wr: assert property (p_duty_wr) else $error("duty write lost"); // RULE6
  // read data must fall back to zero, or a stale byte could be taken for a fresh read
  property p_rdata_idle;
    @(posedge clk) disable iff (rst) !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing"); // RULE6
  property p_out_off;
    @(posedge clk) disable iff (rst) !ctrl_r[0][`DPT_OE_BIT] |=> pwm_out[0] == 1'b0 && pwm_oe[0] == 1'b0;
  endproperty
  a_out_off: assert property (p_out_off) else $error("pin driven while disabled"); // RULE2
  property p_clear_when_off_1;
    @(posedge clk) disable iff (rst) !ctrl_r[1][`DPT_OE_BIT] |=> cnt_r[1] == 8'h00;
  endproperty
  a_clear_when_off_1: assert property (p_clear_when_off_1) else $error("second counter not cleared"); // RULE7
  property p_step;
    @(posedge clk) disable iff (rst)
      ctrl_r[0][`DPT_OE_BIT] && g_ch[0].step && !wr && cnt_r[0] != 8'hF9 |=> cnt_r[0] == $past(cnt_r[0]) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("counter did not step on tick"); // RULE1
  property p_cnt_wr;
    @(posedge clk) disable iff (rst) ctrl_r[1][`DPT_OE_BIT] && wr && sel_cnt[1] |=> cnt_r[1] == $past(wdata);
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("counter write lost"); // RULE3
  property p_div8;
    @(posedge clk) disable iff (rst) tick[1] |=> !tick[1] [*7] ##1 tick[1];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 tick wrong"); // RULE5
  // slow codes are only reached by the bench's short window checks
  c_slow: cover property (@(posedge clk) disable iff (rst) ctrl_r[1][2:0] == 3'h7 && g_ch[1].step);
  c_wrap: cover property (@(posedge clk) disable iff (rst) cnt_r[0] == 8'hF9 ##1 cnt_r[0] == 8'h00);
  c_inv:  cover property (@(posedge clk) disable iff (rst) ctrl_r[1][7] && ctrl_r[1][6] && pwm_out[1]);
  c_read: cover property (@(posedge clk) disable iff (rst) rd && sel_cnt[1]);
endmodule

// *** verification/dpt_load.sv ***
// external load on the pwm pins: resolves the pin level and counts high cycles
`timescale 1ns/100ps
module dpt_load (
  input  wire logic        clk,  // module clock
  input  wire logic        rst,  // async reset, active high
  input  wire logic        clr,  // restart the high count
  input  wire logic        out,  // pwm level from the design
  input  wire logic        oe,   // pin drive enable
  output logic      [31:0] cnt   // high cycles seen since clr
);
  logic lvl;
  // an undriven pin falls to the pull-down, never the last driven level
  assign lvl = oe ? out : 1'b0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt <= '0;
    else if (clr) cnt <= '0;
    else if (lvl === 1'b1) cnt <= cnt + 32'd1;
  end
endmodule

// *** verification/dual_pwm_timer_tb_top.sv ***
// self-checking bench: register access, reset values, pwm duty for prescale codes 0..3 and count steps for codes 4..7
`timescale 1ns/100ps
`include "dpt_params.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module dual_pwm_timer_tb_top;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, clr = 0;
  logic [15:0] addr = '0;
  logic [7:0]  wdata = '0, rdata, e, d;
  logic [1:0]  pwm_out, pwm_oe;
  logic [31:0] cnt, r;
  logic [15:0] b;
  logic [7:0]  q[$];
  int failures = 0, checked = 0;
  dpt_top i_dpt_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                     .rdata(rdata), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
  dpt_load i_dpt_load (.clk(clk), .rst(rst), .clr(clr), .out(pwm_out[0] | pwm_out[1]),
                       .oe(pwm_oe[0] | pwm_oe[1]), .cnt(cnt));
  always #20 clk = ~clk;
  // read data stands only in the cycle after the strobe, so compare exactly there
  always @(posedge clk) begin
    if (rd_d) begin
      e = q.pop_front();
      `CHK("rdata", e, rdata)
    end
    rd_d <= rd;
  end
  task wr_r(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rd_r(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1; q.push_back(v);
    @(posedge clk); rd <= 1'b0;
  endtask
  task close_out;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hE964));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // reset values of both channels plus an unmapped hole
    for (int c = 0; c < 2; c++) begin
      b = `DPT_CH0_CTRL_OFS + c * `DPT_CH_STRIDE;
      rd_r(b, 8'h38); rd_r(b + 16'h1, 8'hFF); rd_r(b + 16'h2, 8'h00);
    end
    rd_r(16'hFFA3, 8'h00);
    $display("test reset values done");
    // fixed control bits, counter write ignored and held at zero while disabled
    for (int c = 0; c < 2; c++) begin
      b = `DPT_CH0_CTRL_OFS + c * `DPT_CH_STRIDE;
      wr_r(b, 8'h00); rd_r(b, 8'h38);
      wr_r(b + 16'h2, 8'h55); rd_r(b + 16'h2, 8'h00);
    end
    $display("test register access done");
    // each window spans one full period, so the high count is phase independent
    for (int k = 0; k < 8; k++) begin
      b = `DPT_CH0_CTRL_OFS + (k % 2) * `DPT_CH_STRIDE;
      r = 32'd2 << (2 * (k / 2));
      d = 8'($urandom_range(1, 249));
      wr_r(b + 16'h1, d); rd_r(b + 16'h1, d);
      wr_r(b, 8'h80 | 8'((k % 2) << 6) | 8'(k / 2));
      repeat (r * 3 + 4) @(posedge clk);
      `CHK("oe", 1'b1, pwm_oe[k % 2])
      @(posedge clk); clr <= 1'b1;
      @(posedge clk); clr <= 1'b0;
      repeat (r * 250) @(posedge clk);
      #1;
      `CHK("high", (k % 2) ? (r * 250 - d * r) : d * r, cnt)
      wr_r(b, 8'h00);
      @(posedge clk); #1;
      `CHK("oe off", 1'b0, pwm_oe[k % 2])
      rd_r(b + 16'h2, 8'h00);
    end
    $display("test pwm duty done");
    // slow codes: any window of exactly one ratio holds exactly one count step
    for (int k = 4; k < 8; k++) begin
      b = `DPT_CH0_CTRL_OFS + (k % 2) * `DPT_CH_STRIDE;
      r = 32'd1 << ((k == 4) ? 8 : k + 5);
      wr_r(b, 8'h80 | 8'(k));
      wr_r(b + 16'h2, 8'h00);
      repeat (r - 1) @(posedge clk);
      rd_r(b + 16'h2, 8'h01);
      wr_r(b, 8'h00);
    end
    $display("test slow prescale done");
    repeat (3) @(posedge clk);
    close_out();
  end
  // watchdog a little beyond the roughly 94k cycles that all windows take
  initial begin
    repeat (99000) @(posedge clk);
    failures++;
    close_out();
  end
endmodule
